/* File: shared/tsb_pkg.sv */
package tsb_pkg;
  // Clock and phase timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FL_SETUP_NS = 40;
  localparam int FL_WAIT_NS = 160;
  localparam int FL_HOLD_NS = 40;
  localparam int SR_SETUP_NS = 5;
  localparam int SR_RD_WAIT_NS = 20;
  localparam int SR_WR_WAIT_NS = 10;
  localparam int SR_HOLD_NS = 10;
  localparam int CNT_W = 6;

  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction : ns_to_cyc

  localparam logic [CNT_W-1:0] FL_SETUP_CYC = ns_to_cyc(FL_SETUP_NS);
  localparam logic [CNT_W-1:0] FL_WAIT_CYC = ns_to_cyc(FL_WAIT_NS);
  localparam logic [CNT_W-1:0] FL_HOLD_CYC = ns_to_cyc(FL_HOLD_NS);
  localparam logic [CNT_W-1:0] SR_SETUP_CYC = ns_to_cyc(SR_SETUP_NS);
  localparam logic [CNT_W-1:0] SR_RD_WAIT_CYC = ns_to_cyc(SR_RD_WAIT_NS);
  localparam logic [CNT_W-1:0] SR_WR_WAIT_CYC = ns_to_cyc(SR_WR_WAIT_NS);
  localparam logic [CNT_W-1:0] SR_HOLD_CYC = ns_to_cyc(SR_HOLD_NS);
  localparam logic [CNT_W-1:0] IDLE_CYC = 6'h01;

  // Bus geometry
  localparam int ADDR_W = 23;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int FL_ADDR_W = 23;
  localparam int FL_DATA_W = 8;
  localparam int SR_ADDR_W = 18;
  localparam int SR_ADDR_LSB = 2;

  typedef enum logic {
    DEV_FLASH = 1'b0,
    DEV_SRAM = 1'b1
  } tsb_dev_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_WAIT = 2'b10,
    ST_HOLD = 2'b11
  } tsb_state_type;

  typedef struct packed {
    logic write;
    tsb_dev_type dev;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] be;
  } tsb_req_type;
endpackage : tsb_pkg

/* File: rtl/tsb_phase_timer.sv */
`timescale 1ns/1ps
module tsb_phase_timer
  import tsb_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic done_o
);
  logic [CNT_W-1:0] cnt_reg;

  // Down counter, done in last phase cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= IDLE_CYC;
    end else if (load_i) begin
      cnt_reg <= count_i;
    end else if (cnt_reg > IDLE_CYC) begin
      cnt_reg <= cnt_reg - IDLE_CYC;
    end
  end

  assign done_o = (cnt_reg == IDLE_CYC);

  a_timer_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (load_i && count_i == 6'h04) |=> !done_o [*3] ##1 done_o)
    else $error("phase timer length wrong");
endmodule : tsb_phase_timer

/* File: rtl/tsb_in_stage.sv */
`timescale 1ns/1ps
module tsb_in_stage
  import tsb_pkg::*;
#(
  parameter bit IN_REG = 1'b1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic valid_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic valid_o,
  output logic [DATA_W-1:0] data_o
);
  generate
    if (IN_REG) begin : g_reg
      logic valid_reg;
      logic [DATA_W-1:0] data_reg;
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          valid_reg <= 1'b0;
          data_reg <= '0;
        end else begin
          valid_reg <= valid_i;
          data_reg <= data_i;
        end
      end
      assign valid_o = valid_reg;
      assign data_o = data_reg;
      a_input_latency: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        valid_i |=> valid_o && data_o == $past(data_i))
        else $error("input stage latency not one cycle");
    end else begin : g_thru
      assign valid_o = valid_i;
      assign data_o = data_i;
    end
  endgenerate
endmodule : tsb_in_stage

/* File: rtl/tsb_bridge.sv */
// Contract
// - Shared address bus always carries the byte address.
// - Memory A0 sits on bus bit 0..4 for 8..128-bit widths.
// - Only as many address lines as the largest memory needs.
// - Registered option registers inputs only, one extra read cycle.
// - Each registering direction adds exactly one cycle, pin timing unchanged.
// - Outputs always registered; input registering selectable, else straight through.
// - No own address; master addresses forwarded unmodified.
// - Flash: 23 address bits, 8-bit data, eight megabytes.
// - Flash: 40 ns setup, 160 ns wait, 40 ns hold in cycles.
// - SRAM: 18 word-address bits, 32-bit data, four low byte enables.
// - SRAM: 5 ns setup, 20 ns read wait, 10 ns write wait, 10 ns hold.
// - SRAM non-pipelined, sampled at wait end, one read outstanding.
// - Address, data, enables, read strobe shared; select, write per device.
// - Flash takes bus bits 0-22; SRAM A0-A17 take bits 2-19.
`timescale 1ns/1ps
module tsb_bridge
  import tsb_pkg::*;
#(
  parameter bit IN_REG = 1'b1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire tsb_req_type req_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [BE_W-1:0] mem_be_low_o,
  output logic bus_rd_strobe_low_o,
  output logic sram_rd_strobe_low_o,
  output logic sram_select_low_o,
  output logic flash_select_low_o,
  output logic sram_wr_strobe_low_o,
  output logic flash_wr_strobe_low_o,
  output logic [DATA_W-1:0] mem_data_o,
  output logic mem_data_oe_low_o,
  input wire logic [DATA_W-1:0] mem_data_i
);
  tsb_state_type state_reg;
  tsb_state_type state_next;
  tsb_req_type req_reg;
  logic pend_reg;
  logic pend_next;
  logic ready_reg;
  logic accept;
  logic timer_load;
  logic timer_done;
  logic [CNT_W-1:0] phase_cyc;
  logic cap_valid_reg;
  logic [DATA_W-1:0] cap_data_reg;
  logic in_valid;
  logic [DATA_W-1:0] in_data;
  logic busy_next;
  logic sel_sram_next;
  logic sel_flash_next;
  logic rd_next;
  logic wr_next;

  assign accept = req_valid_i && ready_reg;
  assign req_ready_o = ready_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      req_reg <= '0;
    end else if (accept) begin
      req_reg <= req_i;
    end
  end

  always_comb begin
    pend_next = pend_reg;
    if (accept) begin
      pend_next = 1'b1;
    end else if (state_next == ST_SETUP) begin
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      ready_reg <= (state_next == ST_IDLE) && !pend_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (pend_reg) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (timer_done) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (timer_done) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (timer_done) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    phase_cyc = IDLE_CYC;
    unique case (state_next)
      ST_IDLE: phase_cyc = IDLE_CYC;
      ST_SETUP: phase_cyc = (req_reg.dev == DEV_SRAM) ? SR_SETUP_CYC : FL_SETUP_CYC;
      ST_WAIT: begin
        if (req_reg.dev == DEV_FLASH) begin
          phase_cyc = FL_WAIT_CYC;
        end else begin
          phase_cyc = req_reg.write ? SR_WR_WAIT_CYC : SR_RD_WAIT_CYC;
        end
      end
      ST_HOLD: phase_cyc = (req_reg.dev == DEV_SRAM) ? SR_HOLD_CYC : FL_HOLD_CYC;
    endcase
  end

  assign timer_load = (state_next != state_reg);

  tsb_phase_timer u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(timer_load),
    .count_i(phase_cyc),
    .done_o(timer_done)
  );

  // Pin values follow the next state
  always_comb begin
    busy_next = (state_next != ST_IDLE);
    sel_sram_next = busy_next && (req_reg.dev == DEV_SRAM);
    sel_flash_next = busy_next && (req_reg.dev == DEV_FLASH);
    rd_next = (state_next == ST_WAIT) && !req_reg.write;
    wr_next = (state_next == ST_WAIT) && req_reg.write;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sram_select_low_o <= 1'b1;
      flash_select_low_o <= 1'b1;
      bus_rd_strobe_low_o <= 1'b1;
      sram_rd_strobe_low_o <= 1'b1;
      sram_wr_strobe_low_o <= 1'b1;
      flash_wr_strobe_low_o <= 1'b1;
    end else begin
      sram_select_low_o <= !sel_sram_next;
      flash_select_low_o <= !sel_flash_next;
      bus_rd_strobe_low_o <= !rd_next;
      sram_rd_strobe_low_o <= !(rd_next && sel_sram_next);
      sram_wr_strobe_low_o <= !(wr_next && sel_sram_next);
      flash_wr_strobe_low_o <= !(wr_next && sel_flash_next);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_addr_o <= '0;
      mem_be_low_o <= '1;
      mem_data_o <= '0;
    end else if (state_next == ST_SETUP && state_reg == ST_IDLE) begin
      mem_addr_o <= req_reg.addr;
      mem_be_low_o <= ~req_reg.be;
      mem_data_o <= req_reg.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_data_oe_low_o <= 1'b1;
    end else begin
      mem_data_oe_low_o <= !(busy_next && req_reg.write);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cap_valid_reg <= 1'b0;
      cap_data_reg <= '0;
    end else begin
      cap_valid_reg <= (state_reg == ST_WAIT) && timer_done && !req_reg.write;
      cap_data_reg <= mem_data_i;
    end
  end

  tsb_in_stage #(
    .IN_REG(IN_REG)
  ) u_in_stage (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .valid_i(cap_valid_reg),
    .data_i(cap_data_reg),
    .valid_o(in_valid),
    .data_o(in_data)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= in_valid;
      rsp_rdata_o <= in_data;
    end
  end

  a_one_select: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sram_select_low_o || flash_select_low_o)
    else $error("two selects asserted");
  a_data_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !mem_data_oe_low_o |-> req_reg.write && state_reg != ST_IDLE)
    else $error("data bus driven outside a write");
  a_addr_forward: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == ST_SETUP) |-> mem_addr_o == req_reg.addr)
    else $error("address not forwarded unmodified");
  a_be_forward: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == ST_SETUP) |-> mem_be_low_o == ~req_reg.be)
    else $error("byte enables not inverted request enables");
  a_addr_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(sram_select_low_o && flash_select_low_o) |=>
      (sram_select_low_o && flash_select_low_o) || $stable(mem_addr_o))
    else $error("address changed inside a transfer");
  a_flash_setup: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(flash_select_low_o) |->
      (bus_rd_strobe_low_o && flash_wr_strobe_low_o) [*8])
    else $error("flash setup too short");
  a_flash_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ($fell(bus_rd_strobe_low_o) && !flash_select_low_o) |->
      ##31 !bus_rd_strobe_low_o ##1 bus_rd_strobe_low_o)
    else $error("flash wait not 160 ns");
  a_sram_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ($fell(sram_select_low_o) && !req_reg.write) |->
      sram_rd_strobe_low_o ##1 !sram_rd_strobe_low_o [*4]
      ##1 sram_rd_strobe_low_o [*2] ##1 sram_select_low_o)
    else $error("sram read phases wrong");
  a_sram_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(sram_wr_strobe_low_o) |->
      !sram_wr_strobe_low_o ##1 !sram_wr_strobe_low_o ##1 sram_wr_strobe_low_o)
    else $error("sram write wait not 10 ns");
  a_rd_share: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sram_rd_strobe_low_o |-> !bus_rd_strobe_low_o && !sram_select_low_o)
    else $error("sram read strobe without shared strobe");
  a_wr_own: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !flash_wr_strobe_low_o |-> !flash_select_low_o && sram_wr_strobe_low_o)
    else $error("flash write strobe on wrong device");
  a_busy_ready: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg != ST_IDLE || pend_reg) |-> !req_ready_o)
    else $error("second request accepted while busy");
  a_read_sample: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(bus_rd_strobe_low_o) |-> cap_valid_reg && cap_data_reg == $past(mem_data_i))
    else $error("read data not sampled at wait end");
  a_rsp_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("response valid longer than one cycle");

  c_sram_read: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    rsp_valid_o && req_reg.dev == DEV_SRAM);
  c_flash_read: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    rsp_valid_o && req_reg.dev == DEV_FLASH);
  c_sram_write: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(sram_wr_strobe_low_o));
  c_flash_write: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(flash_wr_strobe_low_o));
  c_req_waits: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    req_valid_i && !req_ready_o);
endmodule : tsb_bridge

/* File: verif/tsb_mem_model.sv */
`timescale 1ns/1ps
module tsb_mem_model
  import tsb_pkg::*;
(
  input wire logic clk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [BE_W-1:0] be_low_i,
  input wire logic rd_low_i,
  input wire logic sram_sel_low_i,
  input wire logic flash_sel_low_i,
  input wire logic sram_wr_low_i,
  input wire logic flash_wr_low_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic oe_low_i,
  output logic [DATA_W-1:0] bus_o
);
  logic [DATA_W-1:0] sram [int];
  logic [7:0] flash [int];
  logic [DATA_W-1:0] last_reg = '0;
  int wa;
  int fa;
  assign wa = int'(addr_i[SR_ADDR_LSB +: SR_ADDR_W]);
  assign fa = int'(addr_i[FL_ADDR_W-1:0]);
  always @(posedge clk_i) begin
    last_reg <= bus_o;
  end
  always @* begin
    if (oe_low_i === 1'b0) begin
      bus_o = wdata_i;
    end else if (!sram_sel_low_i && !rd_low_i) begin
      bus_o = sram.exists(wa) ? sram[wa] : '0;
    end else if (!flash_sel_low_i && !rd_low_i) begin
      bus_o = {~last_reg[31:8], flash.exists(fa) ? flash[fa] : 8'h00};
    end else begin
      bus_o = ~last_reg;
    end
  end
  always @(posedge sram_wr_low_i) begin
    if (!sram_sel_low_i) begin
      if (!sram.exists(wa)) begin
        sram[wa] = '0;
      end
      for (int b = 0; b < BE_W; b++) begin
        if (!be_low_i[b]) begin
          sram[wa][8*b +: 8] = wdata_i[8*b +: 8];
        end
      end
    end
  end
  always @(posedge flash_wr_low_i) begin
    if (!flash_sel_low_i && !be_low_i[0]) begin
      flash[fa] = wdata_i[7:0];
    end
  end
endmodule : tsb_mem_model

/* File: verif/tsb_bridge_tb_top.sv */
`timescale 1ns/1ps
module tsb_bridge_tb_top
  import tsb_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  tsb_req_type req_i = '0;
  tsb_req_type cur = '0;
  wire logic [33:0] p;
  wire logic [33:0] pu;
  wire logic [DATA_W-1:0] md, mdu, bus, rdat, rdatu;
  wire logic rdy, rdyu, rv, rvu;
  int mismatches = 0;
  int checks = 0;
  int nsel, nwr, nrd, nsrd, noe, nbad;
  logic [31:0] rs = 32'h0000_3210;
  logic [31:0] shs [int];
  logic [7:0] shf [int];

  always #2.5 clk_i = ~clk_i;

  tsb_bridge DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_rdata_o(rdat),
    .mem_addr_o(p[33:11]), .mem_be_low_o(p[10:7]), .bus_rd_strobe_low_o(p[6]),
    .sram_rd_strobe_low_o(p[5]), .sram_select_low_o(p[4]), .flash_select_low_o(p[3]),
    .sram_wr_strobe_low_o(p[2]), .flash_wr_strobe_low_o(p[1]), .mem_data_o(md),
    .mem_data_oe_low_o(p[0]), .mem_data_i(bus));
  tsb_bridge #(.IN_REG(1'b0)) DUT_UNREG (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_ready_o(rdyu), .rsp_valid_o(rvu), .rsp_rdata_o(rdatu),
    .mem_addr_o(pu[33:11]), .mem_be_low_o(pu[10:7]), .bus_rd_strobe_low_o(pu[6]),
    .sram_rd_strobe_low_o(pu[5]), .sram_select_low_o(pu[4]), .flash_select_low_o(pu[3]),
    .sram_wr_strobe_low_o(pu[2]), .flash_wr_strobe_low_o(pu[1]), .mem_data_o(mdu),
    .mem_data_oe_low_o(pu[0]), .mem_data_i(bus));
  tsb_mem_model MEM (.clk_i(clk_i), .addr_i(p[33:11]), .be_low_i(p[10:7]), .rd_low_i(p[6]),
    .sram_sel_low_i(p[4]), .flash_sel_low_i(p[3]), .sram_wr_low_i(p[2]),
    .flash_wr_low_i(p[1]), .wdata_i(md), .oe_low_i(p[0]), .bus_o(bus));

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  function automatic int cyc(input int ns);
    return (ns + 4) / 5;
  endfunction : cyc

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input logic [63:0] g, input logic [63:0] e, input string m);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : cmp

  // Pin monitor, sampled mid-cycle
  always @(negedge clk_i) begin
    if (!sys_rst_i) begin
      cmp(p, pu, "pins");
      cmp(mdu, md, "pin data");
      if (p[4] === 1'b0 || p[3] === 1'b0) begin
        nsel++;
        cmp(p[4:3], (cur.dev == DEV_SRAM) ? 2'b01 : 2'b10, "select");
        cmp(p[33:7], {cur.addr, ~cur.be}, "addr");
      end
      nwr += int'(((cur.dev == DEV_SRAM) ? p[2] : p[1]) === 1'b0);
      nbad += int'(((cur.dev == DEV_SRAM) ? p[1] : p[2]) === 1'b0);
      nrd += int'(p[6] === 1'b0);
      nsrd += int'(p[5] === 1'b0);
      if (p[0] === 1'b0) begin
        noe++;
        cmp(md, cur.wdata, "wdata");
      end
    end
  end

  task automatic xfer(input logic wr, input tsb_dev_type dv, input logic [22:0] a,
      input logic [3:0] be);
    int n, nr, nu, s, w, h, k, cv;
    logic [31:0] d, rd, rdu, ex;
    d = rnd();
    rd = '0;
    rdu = '0;
    cv = 0;
    k = (dv == DEV_SRAM) ? int'(a[19:2]) : int'(a);
    s = (dv == DEV_SRAM) ? cyc(SR_SETUP_NS) : cyc(FL_SETUP_NS);
    w = (dv == DEV_SRAM) ? cyc(wr ? SR_WR_WAIT_NS : SR_RD_WAIT_NS) : cyc(FL_WAIT_NS);
    h = (dv == DEV_SRAM) ? cyc(SR_HOLD_NS) : cyc(FL_HOLD_NS);
    cur = '{write: wr, dev: dv, addr: a, wdata: d, be: be};
    req_i = cur;
    req_valid_i = 1'b1;
    nsel = 0;
    nwr = 0;
    nrd = 0;
    nsrd = 0;
    noe = 0;
    nbad = 0;
    n = 0;
    while (rdy !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 100) begin
        cmp(n, 0, "accept timeout");
        final_report();
      end
    end
    @(posedge clk_i);
    #1;
    req_valid_i = 1'b0;
    req_i.addr = ~a;
    req_i.wdata = ~d;
    n = 0;
    nr = 0;
    nu = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
      if (rv === 1'b1) begin
        nr = n;
        rd = rdat;
      end
      if (rvu === 1'b1) begin
        nu = n;
        rdu = rdatu;
      end
      cv += int'(rv === 1'b1) + int'(rvu === 1'b1);
    end while (rdy !== 1'b1 && n < 300);
    cmp(n, 1 + s + w + h, "busy");
    if (n >= 300) begin
      final_report();
    end
    cmp(nsel, s + w + h, "select span");
    cmp(wr ? nwr : nrd, w, "strobe");
    cmp(nsrd, (!wr && dv == DEV_SRAM) ? w : 0, "sram rd");
    cmp(nbad + (wr ? nrd : nwr), 0, "stray strobe");
    cmp(noe, wr ? s + w + h : 0, "drive");
    cmp(cv, wr ? 0 : 2, "rsp pulses");
    if (wr) begin
      ex = shs.exists(k) ? shs[k] : '0;
      for (int b = 0; b < 4; b++) begin
        if (be[b]) begin
          ex[8*b +: 8] = d[8*b +: 8];
        end
      end
      if (dv == DEV_SRAM) begin
        shs[k] = ex;
      end else if (be[0]) begin
        shf[k] = d[7:0];
      end
    end else begin
      cmp(nr, 3 + s + w, "rd latency");
      cmp(nu, 2 + s + w, "unreg latency");
      ex = (dv == DEV_SRAM) ? (shs.exists(k) ? shs[k] : '0)
                            : {24'h0, shf.exists(k) ? shf[k] : 8'h00};
      cmp((dv == DEV_SRAM) ? rd : {24'h0, rd[7:0]}, ex, "rdata");
      cmp((dv == DEV_SRAM) ? rdu : {24'h0, rdu[7:0]}, ex, "unreg rdata");
    end
  endtask : xfer

  initial begin
    logic [31:0] r;
    repeat (20) @(posedge clk_i);
    #1;
    cmp({rdy, p}, {1'b0, 34'h0_0000_07FF}, "reset pins");
    sys_rst_i = 1'b0;
    xfer(1'b1, DEV_SRAM, 23'h0FFFFC, 4'hF);
    xfer(1'b0, DEV_SRAM, 23'h0FFFFC, 4'hF);
    xfer(1'b1, DEV_SRAM, 23'h700008, 4'h5);
    xfer(1'b0, DEV_SRAM, 23'h000008, 4'hF);
    xfer(1'b1, DEV_FLASH, 23'h7FFFFF, 4'h1);
    xfer(1'b0, DEV_FLASH, 23'h7FFFFF, 4'hF);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      xfer(1'b1, tsb_dev_type'(r[31]), r[22:0], r[26:23]);
      xfer(1'b0, tsb_dev_type'(r[31]), r[22:0] ^ {22'h0, r[27]}, r[30:27]);
    end
    final_report();
  end
endmodule : tsb_bridge_tb_top
